//--- design/ddrcd_map.vh
`ifndef DDRCD_MAP_VH
`define DDRCD_MAP_VH
// ----------------------------------------
// command codes (one-hot decoder outputs)
// ----------------------------------------
`define DDRCD_CMD_W 11
`define DDRCD_CMD_DESEL 11'h0_001
`define DDRCD_CMD_NOP 11'h0_002
`define DDRCD_CMD_MODE_LD 11'h0_004
`define DDRCD_CMD_EXT_LD 11'h0_008
`define DDRCD_CMD_ACT 11'h0_010
`define DDRCD_CMD_RD 11'h0_020
`define DDRCD_CMD_WR 11'h0_040
`define DDRCD_CMD_PRE 11'h0_080
`define DDRCD_CMD_BST 11'h0_100
`define DDRCD_CMD_REF 11'h0_200
`define DDRCD_CMD_SREF 11'h0_400
// ----------------------------------------
// field positions
// ----------------------------------------
`define DDRCD_AUTOPRE_BIT 10
`define DDRCD_ADDR_W 13
`define DDRCD_BANK_W 2
`define DDRCD_OPER_W 15
`define DDRCD_NBANK 4
`define DDRCD_BANKS_ALL 4'hf
`define DDRCD_BANKS_NONE 4'h0
`define DDRCD_COL_W 9
`endif

//--- design/ddrcd_lane.v
`default_nettype none
`include "ddrcd_map.vh"
// ----------------------------------------
// one byte lane: strobe-timed capture with mask
// ----------------------------------------
module ddrcd_lane (
  // clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // pins, already synchronised
  input wire i_strobe,
  input wire i_mask,
  input wire [7:0] i_data,
  // control
  input wire i_wr_active,
  // captured beat
  output reg o_beat_valid,
  output reg [7:0] o_beat_data
);
  reg strobe_last_reg;
  wire strobe_edge;
  assign strobe_edge = i_strobe ^ strobe_last_reg;
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      strobe_last_reg <= 1'b0;
      o_beat_valid <= 1'b0;
      o_beat_data <= 8'h00;
    end else begin
      strobe_last_reg <= i_strobe;
      // each edge carries its own mask; masked beats are not stored
      o_beat_valid <= i_wr_active & strobe_edge & ~i_mask;
      if (i_wr_active & strobe_edge & ~i_mask) begin
        o_beat_data <= i_data;
      end
    end
  end
endmodule // ddrcd_lane
`default_nettype wire

//--- design/ddrcd_top.v
`default_nettype none
`include "ddrcd_map.vh"
module ddrcd_top #(
  parameter ADDR_W = `DDRCD_ADDR_W,
  parameter BANK_W = `DDRCD_BANK_W
) (
  // clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // command pins
  input wire i_link_clk,
  input wire i_clk_en,
  input wire i_chip_sel_n,
  input wire i_row_strobe_n,
  input wire i_col_strobe_n,
  input wire i_write_en_n,
  input wire [ADDR_W-1:0] i_addr,
  input wire [BANK_W-1:0] i_bank_select_lines,
  // data lane pins
  input wire i_lower_byte_mask,
  input wire i_upper_byte_mask,
  input wire [15:0] i_dq,
  output reg [15:0] o_dq,
  output reg o_dq_oe,
  input wire i_lower_byte_strobe,
  output reg o_lower_byte_strobe,
  output reg o_lower_byte_strobe_oe,
  input wire i_upper_byte_strobe,
  output reg o_upper_byte_strobe,
  output reg o_upper_byte_strobe_oe,
  // read data source from array
  input wire [15:0] i_rd_data,
  // decoded results
  output reg [`DDRCD_CMD_W-1:0] o_cmd,
  output reg o_mode_register_load,
  output reg o_extended_mode_register_load,
  output reg [`DDRCD_OPER_W-1:0] o_register_operand,
  output reg [ADDR_W-1:0] o_row_addr,
  output reg [`DDRCD_COL_W-1:0] o_col_addr,
  output reg o_auto_precharge_flag,
  output reg [BANK_W-1:0] o_bank,
  output reg [`DDRCD_NBANK-1:0] o_precharge_banks,
  output reg o_power_down,
  output reg o_self_refresh,
  // captured write data
  output reg [1:0] o_wr_beat_valid,
  output reg [15:0] o_wr_beat_data
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam SYNC_W = 8 + ADDR_W + BANK_W + 16;
  wire [SYNC_W-1:0] pins_raw;
  reg [SYNC_W-1:0] sync1_reg;
  reg [SYNC_W-1:0] sync2_reg;
  assign pins_raw = {i_link_clk, i_clk_en, i_chip_sel_n, i_row_strobe_n, i_col_strobe_n,
                     i_write_en_n, i_addr, i_bank_select_lines, i_lower_byte_mask,
                     i_upper_byte_mask, i_dq};
  wire ck_s, cke_s, cs_n, ras_n, cas_n, we_n, lmask_s, umask_s;
  wire [ADDR_W-1:0] addr_s;
  wire [BANK_W-1:0] ba_s;
  wire [15:0] dq_s;
  assign {ck_s, cke_s, cs_n, ras_n, cas_n, we_n, addr_s, ba_s, lmask_s, umask_s, dq_s} = sync2_reg;
  reg [1:0] dqs_sync1_reg;
  reg [1:0] dqs_sync2_reg;
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      sync1_reg <= {SYNC_W{1'b0}};
      sync2_reg <= {SYNC_W{1'b0}};
      dqs_sync1_reg <= 2'h0;
      dqs_sync2_reg <= 2'h0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      dqs_sync1_reg <= {i_upper_byte_strobe, i_lower_byte_strobe};
      dqs_sync2_reg <= dqs_sync1_reg;
    end
  end
  // ----------------------------------------
  // link clock edge and command decode
  // ----------------------------------------
  reg ck_last_reg;
  reg cke_prev_reg;
  wire ck_rise;
  assign ck_rise = ck_s & ~ck_last_reg;
  reg [`DDRCD_CMD_W-1:0] cmd_dec;
  // mask pins are absent from this decode
  always @* begin
    cmd_dec = `DDRCD_CMD_NOP;
    if (cs_n) begin
      cmd_dec = `DDRCD_CMD_DESEL;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'b000: cmd_dec = ba_s[0] ? `DDRCD_CMD_EXT_LD : `DDRCD_CMD_MODE_LD;
        3'b011: cmd_dec = `DDRCD_CMD_ACT;
        3'b101: cmd_dec = `DDRCD_CMD_RD;
        3'b100: cmd_dec = `DDRCD_CMD_WR;
        3'b010: cmd_dec = `DDRCD_CMD_PRE;
        3'b110: cmd_dec = `DDRCD_CMD_BST;
        3'b001: cmd_dec = cke_s ? `DDRCD_CMD_REF : `DDRCD_CMD_SREF;
        default: cmd_dec = `DDRCD_CMD_NOP;
      endcase
    end
  end
  wire idle_cmd;
  assign idle_cmd = cs_n | (ras_n & cas_n & we_n);
  // ----------------------------------------
  // power state machine (one-hot)
  // ----------------------------------------
  localparam ST_RUN = 3'b001;
  localparam ST_PDN = 3'b010;
  localparam ST_SREF = 3'b100;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (cke_prev_reg & ~cke_s) begin
          if (idle_cmd) state_next = ST_PDN;
          else if (cmd_dec == `DDRCD_CMD_SREF) state_next = ST_SREF;
        end
      end
      ST_PDN, ST_SREF: begin
        if (cke_s & idle_cmd) state_next = ST_RUN;
      end
      default: state_next = ST_RUN;
    endcase
  end
  // ----------------------------------------
  // command outputs
  // ----------------------------------------
  wire cmd_take;
  assign cmd_take = ck_rise & cke_prev_reg & (state_reg == ST_RUN);
  reg [1:0] wr_active_reg;
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      ck_last_reg <= 1'b0;
      cke_prev_reg <= 1'b0;
      state_reg <= ST_RUN;
      o_cmd <= `DDRCD_CMD_DESEL;
      o_mode_register_load <= 1'b0;
      o_extended_mode_register_load <= 1'b0;
      o_register_operand <= {`DDRCD_OPER_W{1'b0}};
      o_row_addr <= {ADDR_W{1'b0}};
      o_col_addr <= {`DDRCD_COL_W{1'b0}};
      o_auto_precharge_flag <= 1'b0;
      o_bank <= {BANK_W{1'b0}};
      o_precharge_banks <= `DDRCD_BANKS_NONE;
      o_power_down <= 1'b0;
      o_self_refresh <= 1'b0;
      wr_active_reg <= 2'b00;
    end else begin
      ck_last_reg <= ck_s;
      o_cmd <= `DDRCD_CMD_DESEL;
      o_mode_register_load <= 1'b0;
      o_extended_mode_register_load <= 1'b0;
      o_precharge_banks <= `DDRCD_BANKS_NONE;
      if (ck_rise) begin
        cke_prev_reg <= cke_s;
        state_reg <= state_next;
        o_power_down <= state_next == ST_PDN;
        o_self_refresh <= state_next == ST_SREF;
      end
      if (cmd_take) begin
        o_cmd <= cmd_dec;
        o_bank <= ba_s;
        case (cmd_dec)
          `DDRCD_CMD_MODE_LD, `DDRCD_CMD_EXT_LD: begin
            o_register_operand <= {ba_s, addr_s};
            o_mode_register_load <= cmd_dec == `DDRCD_CMD_MODE_LD;
            o_extended_mode_register_load <= cmd_dec == `DDRCD_CMD_EXT_LD;
          end
          `DDRCD_CMD_ACT: o_row_addr <= addr_s;
          `DDRCD_CMD_RD, `DDRCD_CMD_WR: begin
            o_col_addr <= addr_s[`DDRCD_COL_W-1:0];
            o_auto_precharge_flag <= addr_s[`DDRCD_AUTOPRE_BIT];
            wr_active_reg <= (cmd_dec == `DDRCD_CMD_WR) ? 2'b11 : 2'b00;
          end
          `DDRCD_CMD_PRE: begin
            o_precharge_banks <= addr_s[`DDRCD_AUTOPRE_BIT] ? `DDRCD_BANKS_ALL :
              (4'h1 << ba_s);
          end
          `DDRCD_CMD_BST: wr_active_reg <= 2'b00;
          default: wr_active_reg <= wr_active_reg;
        endcase
      end
    end
  end
  // ----------------------------------------
  // byte lanes
  // ----------------------------------------
  wire [1:0] mask_s;
  assign mask_s = {umask_s, lmask_s};
  wire [1:0] lane_valid;
  wire [15:0] lane_data;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      ddrcd_lane u_lane (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_strobe(dqs_sync2_reg[g]),
        .i_mask(mask_s[g]),
        .i_data(dq_s[8*g+7:8*g]),
        .i_wr_active(wr_active_reg[g]),
        .o_beat_valid(lane_valid[g]),
        .o_beat_data(lane_data[8*g+7:8*g])
      );
    end
  endgenerate
  // read path: strobe toggles with each data beat
  reg rd_active_reg;
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      rd_active_reg <= 1'b0;
      o_dq <= 16'h0000;
      o_dq_oe <= 1'b0;
      o_lower_byte_strobe <= 1'b0;
      o_lower_byte_strobe_oe <= 1'b0;
      o_upper_byte_strobe <= 1'b0;
      o_upper_byte_strobe_oe <= 1'b0;
      o_wr_beat_valid <= 2'b00;
      o_wr_beat_data <= 16'h0000;
    end else begin
      o_wr_beat_valid <= lane_valid;
      o_wr_beat_data <= lane_data;
      if (cmd_take) begin
        rd_active_reg <= cmd_dec == `DDRCD_CMD_RD ||
          (rd_active_reg && cmd_dec != `DDRCD_CMD_BST && cmd_dec != `DDRCD_CMD_WR);
      end
      o_dq_oe <= rd_active_reg;
      o_lower_byte_strobe_oe <= rd_active_reg;
      o_upper_byte_strobe_oe <= rd_active_reg;
      if (rd_active_reg && ck_s != ck_last_reg) begin
        o_dq <= i_rd_data;
        o_lower_byte_strobe <= ck_s;
        o_upper_byte_strobe <= ck_s;
      end
    end
  end
endmodule // ddrcd_top
`default_nettype wire

//--- bench/ddrcd_monitor.sv
`default_nettype none
`include "ddrcd_map.vh"
module ddrcd_monitor (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // decoded results
  input wire logic [`DDRCD_CMD_W-1:0] i_cmd,
  input wire logic i_mode_ld,
  input wire logic i_ext_ld,
  input wire logic [`DDRCD_NBANK-1:0] i_pre_banks,
  input wire logic i_power_down,
  input wire logic i_self_refresh,
  // lanes
  input wire logic i_dq_oe,
  input wire logic [1:0] i_wr_beat_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  sequence oe_s;
    ##[1:3] i_dq_oe;
  endsequence
  one_cmd_a: assert property ($onehot(i_cmd)) else $error("cmd not one-hot");
  mode_ld_a: assert property (i_mode_ld == (i_cmd == `DDRCD_CMD_MODE_LD))
    else $error("mode load");
  ext_ld_a: assert property (i_ext_ld == (i_cmd == `DDRCD_CMD_EXT_LD))
    else $error("ext load");
  pre_cause_a: assert property (i_pre_banks != 4'h0 |-> i_cmd == `DDRCD_CMD_PRE)
    else $error("stray precharge");
  pwr_excl_a: assert property (!(i_power_down && i_self_refresh)) else $error("both");
  pwr_refuse_a: assert property (i_power_down || i_self_refresh |->
    !(i_cmd inside {`DDRCD_CMD_ACT, `DDRCD_CMD_RD, `DDRCD_CMD_WR})) else $error("cmd taken");
  rd_oe_a: assert property (i_cmd == `DDRCD_CMD_RD |-> oe_s) else $error("no drive");
  beat_dir_a: assert property (i_wr_beat_valid != 2'h0 |-> !i_dq_oe)
    else $error("beat while driving");
endmodule // ddrcd_monitor
bind ddrcd_top ddrcd_monitor u_mon (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cmd(o_cmd),
  .i_mode_ld(o_mode_register_load), .i_ext_ld(o_extended_mode_register_load),
  .i_pre_banks(o_precharge_banks), .i_power_down(o_power_down),
  .i_self_refresh(o_self_refresh), .i_dq_oe(o_dq_oe), .i_wr_beat_valid(o_wr_beat_valid));
`default_nettype wire

//--- bench/ddrcd_ctl_model.sv
`default_nettype none
module ddrcd_ctl_model (
  // clock
  input wire logic i_mclk,
  // link clock and write lanes
  output logic o_lk,
  output logic o_ls,
  output logic o_us,
  output logic o_lm,
  output logic o_um,
  output logic [15:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  assign o_lk = cnt[3];
  initial {o_ls, o_us, o_lm, o_um, o_dq} = 20'h0_0000;
  always @(negedge i_mclk) begin
    cnt <= cnt + 4'h1;
  end
  // data and mask set ahead of the strobe edge, then driven to their inverse
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    @(negedge i_mclk);
    {o_dq, o_um, o_lm} = {d, m};
    repeat (2) @(negedge i_mclk);
    {o_ls, o_us} = ~{o_ls, o_us};
    repeat (6) @(negedge i_mclk);
    {o_dq, o_um, o_lm} = ~{d, m};
  endtask
endmodule // ddrcd_ctl_model
`default_nettype wire

//--- bench/ddr_sdram_command_decode_tb_top.sv
`default_nettype none
`include "ddrcd_map.vh"
module ddr_sdram_command_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BURST_LEN = 4, ROW_PRE = 3, WR_REC = 2;
  logic mclk = 1'b0, nrst = 1'b0;
  logic cke = 1'b1;
  logic [3:0] pins = 4'h7, pb;
  logic [12:0] addr = 13'h0000;
  logic [1:0] bank = 2'h0, msk = 2'h0, ld;
  logic [10:0] got;
  wire lk, ls, us, lm, um, oe, lsd, lso, usd, uso, mode_ld, ext_ld, ap, pd, sr;
  wire [15:0] dqm, dqd, bd;
  wire [10:0] cmd;
  wire [14:0] opr;
  wire [12:0] row;
  wire [8:0] col;
  wire [1:0] bnk, bv;
  wire [3:0] pre;
  int num_errors = 0, cmp_count = 0;
  initial forever #2 mclk = ~mclk;
  ddrcd_ctl_model u_ctl (.i_mclk(mclk), .o_lk(lk), .o_ls(ls), .o_us(us), .o_lm(lm),
    .o_um(um), .o_dq(dqm));
  ddrcd_top i_dut (.i_mclk(mclk), .i_nrst(nrst), .i_link_clk(lk), .i_clk_en(cke),
    .i_chip_sel_n(pins[3]), .i_row_strobe_n(pins[2]), .i_col_strobe_n(pins[1]),
    .i_write_en_n(pins[0]), .i_addr(addr), .i_bank_select_lines(bank),
    .i_lower_byte_mask(lm | msk[0]), .i_upper_byte_mask(um | msk[1]),
    .i_dq(oe ? dqd : dqm), .o_dq(dqd), .o_dq_oe(oe), .i_lower_byte_strobe(lso ? lsd : ls),
    .o_lower_byte_strobe(lsd), .o_lower_byte_strobe_oe(lso),
    .i_upper_byte_strobe(uso ? usd : us), .o_upper_byte_strobe(usd),
    .o_upper_byte_strobe_oe(uso), .i_rd_data(16'hc35a), .o_cmd(cmd),
    .o_mode_register_load(mode_ld), .o_extended_mode_register_load(ext_ld),
    .o_register_operand(opr), .o_row_addr(row), .o_col_addr(col),
    .o_auto_precharge_flag(ap), .o_bank(bnk), .o_precharge_banks(pre),
    .o_power_down(pd), .o_self_refresh(sr), .o_wr_beat_valid(bv), .o_wr_beat_data(bd));
  task automatic chk(input logic ok, input string s);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask
  // one command across a link rising edge, decode caught when it pulses
  task automatic io(input logic [3:0] p, input logic [1:0] b, input logic [12:0] a);
    got = `DDRCD_CMD_DESEL;
    @(negedge lk);
    @(negedge mclk);
    {pins, bank, addr} = {p, b, a};
    for (int i = 0; i < 14 && got === `DDRCD_CMD_DESEL; i++) begin
      @(posedge mclk);
      #1 {got, ld, pb} = {cmd, ext_ld, mode_ld, pre};
    end
    @(negedge lk);
    @(negedge mclk);
    pins = 4'h7;
  endtask
  task automatic t_decode;
    logic [3:0] pat [9] = '{4'h7, 4'h3, 4'h5, 4'h6, 4'h4, 4'h6, 4'h2, 4'h1, 4'hf};
    logic [10:0] ex [9] = '{11'h002, 11'h010, 11'h020, 11'h100, 11'h040, 11'h100,
      11'h080, 11'h200, 11'h001};
    msk = 2'h3;
    foreach (pat[i]) begin
      io(pat[i], 2'h1, 13'h0000);
      chk(got === ex[i], "decode");
    end
    msk = 2'h0;
  endtask
  task automatic t_load;
    io(4'h2, 2'h2, 13'h1bff);
    chk(pb === 4'h4, "one bank");
    io(4'h2, 2'h2, 13'h17ff);
    chk(pb === 4'hf, "all banks");
    repeat (ROW_PRE) @(negedge lk);
    io(4'h0, 2'h0, 13'h12a5);
    chk(got === `DDRCD_CMD_MODE_LD && ld === 2'h1 && opr === 15'h12a5, "mode");
    io(4'h0, 2'h3, 13'h0c3a);
    chk(got === `DDRCD_CMD_EXT_LD && ld === 2'h2 && opr === 15'h6c3a, "ext");
  endtask
  task automatic t_read;
    io(4'h3, 2'h3, 13'h1555);
    chk(row === 13'h1555 && bnk === 2'h3, "row");
    io(4'h5, 2'h3, 13'h04ab);
    repeat (4) @(negedge mclk);
    chk(col === 9'h0ab && {ap, oe, lso, uso} === 4'hf && dqd === 16'hc35a &&
      {lsd, usd} === 2'h0, "read");
    @(posedge lk);
    repeat (4) @(negedge mclk);
    chk({lsd, usd, oe} === 3'h7, "strobe rise");
    io(4'h6, 2'h0, 13'h0000);
    chk(oe === 1'b0, "stop");
    repeat (BURST_LEN / 2 + ROW_PRE) @(negedge lk);
  endtask
  task automatic wbeat(input logic [15:0] d, input logic [1:0] m);
    logic [1:0] v;
    logic [15:0] q, k;
    v = 2'h0;
    k = {{8{~m[1]}}, {8{~m[0]}}};
    fork
      u_ctl.beat(d, m);
      for (int i = 0; i < 14 && v === 2'h0; i++) begin
        @(posedge mclk);
        #1 {v, q} = {bv, bd};
      end
    join
    chk(v === ~m && (q & k) === (d & k), "beat");
  endtask
  task automatic t_write;
    io(4'h4, 2'h0, 13'h0400);
    wbeat(16'ha1b2, 2'h0);
    wbeat(16'hc4d5, 2'h1);
    wbeat(16'he6f7, 2'h2);
    io(4'h6, 2'h0, 13'h0000);
    repeat (BURST_LEN / 2 + 1 + WR_REC + ROW_PRE) @(negedge lk);
  endtask
  task automatic t_power(input logic [3:0] p, input logic [1:0] want);
    @(negedge lk);
    @(negedge mclk);
    {pins, cke} = {p, 1'b0};
    repeat (12) @(negedge mclk);
    pins = 4'h7;
    repeat (20) @(negedge mclk);
    chk({sr, pd} === want, "power entry");
    cke = 1'b1;
    repeat (32) @(negedge mclk);
    chk({sr, pd} === 2'h0, "power exit");
  endtask
  task automatic summarize;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    repeat (32) @(negedge mclk);
    t_decode;
    t_load;
    t_read;
    t_write;
    t_power(4'h7, 2'h1);
    t_power(4'h1, 2'h2);
    summarize;
  end
  initial begin
    #60000;
    num_errors++;
    summarize;
  end
endmodule // ddr_sdram_command_decode_tb_top
`default_nettype wire
